// ==== src/data_arith_unit_sat_sub_pkg.sv ====
// Constants and types for the saturate and subtract datapath slice
package data_arith_unit_sat_sub_pkg;
  localparam int DW = 40;
  localparam int HIGH_LSB = 16;
  localparam int EXT_MSB = 39;
  localparam int EXT_LSB = 32;
  localparam int SIGN32 = 31;
  localparam logic [39:0] FRAC_POS = 40'h007FFF0000;
  localparam logic [39:0] NEG_CLAMP = 40'hFF80000000;
  localparam logic [39:0] LONG_POS = 40'h007FFFFFFF;
  localparam logic [39:0] LOW_MASK = 40'hFFFFFF0000;
  localparam logic [39:0] ZERO40 = 40'h0000000000;
  localparam logic [2:0] REG_INIT = 3'h0;
  // Scaling mode encodings in status_word bits 5:4
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [1:0] SCALE_DOWN = 2'h1;
  localparam logic [1:0] SCALE_UP = 2'h2;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SAT_FRAC,
    OP_SAT_LONG,
    OP_SUB_BORROW,
    OP_SUB_ROUND
  } op_t;
endpackage : data_arith_unit_sat_sub_pkg

// ==== src/data_arith_unit_sat_sub.sv ====
// Saturate, subtract-with-borrow and subtract-round datapath slice
//
// What this block does
// RQ1: Frac saturate, no overflow: copy, zero low_portion
// RQ2: Frac saturate overflow: clamp 007FFF0000 or FF80000000
// RQ3: Long saturate, no overflow: value unchanged
// RQ4: Long saturate overflow: clamp 007FFFFFFF or FF80000000
// RQ5: Saturate ops ignore saturation_mode bit
// RQ6: Saturates clear limit_tag; overflow flag only on clamp
// RQ7: Borrow subtract: second minus first minus carry
// RQ8: Pair field 00..11 selects D0D1 to D6D7
// RQ9: Carry becomes borrow out of subtraction
// RQ10: Carry meaningful only with sign-extended destination
// RQ11: Borrow subtract flags overflow beyond 40 bits
// RQ12: Limit tag uses scaling bits status_word[5:4]
// RQ13: Subtract then round high_portion, zero bits below the result LSB unless clamped
// RQ14: round_select bit picks method; scaling moves point
// RQ15: Round overflow flag: 40-bit overflow or clamp
// RQ16: Round limit_tag computed if unsaturated, else cleared
// RQ17: Scale-up limit tag tracks overflow from bit 30
// RQ18: Saturation mode clamps round result to 32 bits
// RQ19: Convergent when round_select clear, else two's complement
// RQ20: Single cycle; flags visible to next set
`timescale 1ns/1ps
module data_arith_unit_sat_sub (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // Instruction from the decoder
  input  wire logic                   opValid,
  input  wire data_arith_unit_sat_sub_pkg::op_t  opCode,
  input  wire logic [1:0]             pairSel,
  input  wire logic [2:0]             srcSel,
  input  wire logic [2:0]             dstSel,
  // Register file reads
  input  wire logic [39:0]            srcData,
  input  wire logic [39:0]            dstData,
  input  wire logic [39:0]            pairFirst,
  input  wire logic [39:0]            pairSecond,
  // Status word inputs
  input  wire logic                   saturationMode,
  input  wire logic                   roundSelect,
  input  wire logic [1:0]             scaleMode,
  input  wire logic                   carryIn,
  // Register file write-back
  output logic                        wrEn,
  output logic [2:0]                  wrIdx,
  output logic [39:0]                 wrData,
  output logic                        limitTag,
  // Read index for the pair
  output logic [2:0]                  pairFirstIdx,
  output logic [2:0]                  pairSecondIdx,
  // Flags
  output logic                        carryOut,
  output logic                        carryWr,
  output logic                        dataOverflowFlag
);
  import data_arith_unit_sat_sub_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when bits 39..31 are not all equal
  function automatic logic ovf32(input logic [39:0] v);
    ovf32 = !((&v[EXT_MSB:SIGN32]) || !(|v[EXT_MSB:SIGN32]));
  endfunction : ovf32

  // Limit tag from 41-bit true result according to scaling
  function automatic logic limitOf(input logic [40:0] r, input logic [1:0] s);
    logic [40:0] t;
    t = r;
    case (s)
      SCALE_DOWN: limitOf = !((&t[40:32]) || !(|t[40:32]));
      SCALE_UP:   limitOf = !((&t[40:30]) || !(|t[40:30]));
      default:    limitOf = !((&t[40:31]) || !(|t[40:31]));
    endcase
  endfunction : limitOf

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rstMeta;
  logic rstSync;

  // Two flops release the reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ----------------------------------------------------------------
  // Saturation ops
  // ----------------------------------------------------------------
  logic        srcOvf;
  logic [39:0] fracRes;
  logic [39:0] longRes;

  assign srcOvf = ovf32(srcData);
  // Clamp choice ignores saturation mode entirely  RQ5
  assign fracRes = srcOvf ? (srcData[EXT_MSB] ? NEG_CLAMP : FRAC_POS) // RQ2
                          : (srcData & LOW_MASK); // RQ1
  assign longRes = srcOvf ? (srcData[EXT_MSB] ? NEG_CLAMP : LONG_POS) // RQ4
                          : srcData; // RQ3

  // ----------------------------------------------------------------
  // Subtract with borrow
  // ----------------------------------------------------------------
  logic [40:0] sbcFull;
  logic [41:0] sbcUns;
  logic        sbcOvf;

  // Second minus first minus carry, sign extended  RQ7
  assign sbcFull = {pairSecond[39], pairSecond} - {pairFirst[39], pairFirst}
                   - {40'h0000000000, carryIn};
  // Borrow out of the unsigned 40-bit subtract  RQ9 RQ10
  assign sbcUns = {2'h0, pairSecond} - {2'h0, pairFirst} - {41'h00000000000, carryIn};
  assign sbcOvf = sbcFull[40] != sbcFull[39]; // RQ11

  // ----------------------------------------------------------------
  // Subtract and round
  // ----------------------------------------------------------------
  logic [40:0] sbrDiff;
  logic [40:0] sbrRnd;
  logic [40:0] rndBit;
  logic [40:0] keepMask;
  logic [40:0] tieMask;
  logic [40:0] lsbMask;
  logic        sbrOvf40;
  logic        sbrClamp;
  logic [39:0] sbrRes;

  assign sbrDiff = {dstData[39], dstData} - {srcData[39], srcData}; // RQ13

  // Rounding point moves with scaling  RQ14 RQ19
  always_comb begin
    case (scaleMode)
      SCALE_DOWN: begin
        rndBit  = 41'h00000010000;
        keepMask = 41'h1FFFFFE0000;
        lsbMask = 41'h00000020000;
      end
      SCALE_UP: begin
        rndBit  = 41'h00000004000;
        keepMask = 41'h1FFFFFF8000;
        lsbMask = 41'h00000008000;
      end
      default: begin
        rndBit  = 41'h00000008000;
        keepMask = 41'h1FFFFFF0000;
        lsbMask = 41'h00000010000;
      end
    endcase
    tieMask = ~keepMask;
  end

  // Convergent clears LSB on exact half; otherwise plain add  RQ19
  always_comb begin
    logic [40:0] sum;
    sum = sbrDiff + rndBit;
    if (!roundSelect && ((sbrDiff & tieMask) == rndBit)) begin
      sbrRnd = sum & keepMask & ~lsbMask;
    end else begin
      sbrRnd = sum & keepMask;
    end
  end

  assign sbrOvf40 = sbrRnd[40] != sbrRnd[39];
  assign sbrClamp = saturationMode && !((&sbrRnd[40:31]) || !(|sbrRnd[40:31]));
  // Clamp by true sign in saturation mode  RQ18
  assign sbrRes = sbrClamp ? (sbrRnd[40] ? NEG_CLAMP : LONG_POS) : sbrRnd[39:0];

  // ----------------------------------------------------------------
  // Pair index decode
  // ----------------------------------------------------------------
  // Fixed pair decode from the two-bit field  RQ8
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      pairFirstIdx  <= REG_INIT;
      pairSecondIdx <= REG_INIT;
    end else begin
      pairFirstIdx  <= {pairSel, 1'b0}; // RQ8
      pairSecondIdx <= {pairSel, 1'b1}; // RQ8
    end
  end

  // ----------------------------------------------------------------
  // Write-back, limit tag and flags
  // ----------------------------------------------------------------
  // One cycle from opValid to registered result  RQ20
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      wrEn     <= 1'b0;
      wrIdx    <= REG_INIT;
      wrData   <= ZERO40;
      limitTag <= 1'b0;
      carryWr  <= 1'b0;
      carryOut <= 1'b0;
      dataOverflowFlag <= 1'b0;
    end else begin
      wrEn    <= 1'b0;
      carryWr <= 1'b0;
      dataOverflowFlag <= 1'b0;
      if (opValid) begin
        case (opCode)
          OP_SAT_FRAC: begin
            wrEn     <= 1'b1;
            wrIdx    <= dstSel;
            wrData   <= fracRes;
            limitTag <= 1'b0; // RQ6
            dataOverflowFlag <= srcOvf; // RQ6
          end
          OP_SAT_LONG: begin
            wrEn     <= 1'b1;
            wrIdx    <= dstSel;
            wrData   <= longRes;
            limitTag <= 1'b0; // RQ6
            dataOverflowFlag <= srcOvf; // RQ6
          end
          OP_SUB_BORROW: begin
            wrEn     <= 1'b1;
            wrIdx    <= {pairSel, 1'b1}; // RQ7
            wrData   <= sbcFull[39:0];
            limitTag <= limitOf(sbcFull, scaleMode); // RQ12 RQ17
            carryWr  <= 1'b1;
            carryOut <= sbcUns[40]; // RQ9
            dataOverflowFlag <= sbcOvf; // RQ11
          end
          OP_SUB_ROUND: begin
            wrEn     <= 1'b1;
            wrIdx    <= dstSel;
            wrData   <= sbrRes; // RQ13
            limitTag <= saturationMode ? 1'b0 : limitOf(sbrRnd, scaleMode); // RQ16 RQ12
            dataOverflowFlag <= sbrOvf40 || sbrClamp; // RQ15
          end
          default: begin
            wrEn <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_frac_low_zero: assert property (@(posedge clk) disable iff (!rstSync) // RQ1
    opValid && opCode == OP_SAT_FRAC |=> wrEn && wrData[15:0] == 16'h0000)
    else $error("frac saturate left low portion nonzero");

  a_frac_clamp: assert property (@(posedge clk) disable iff (!rstSync) // RQ2
    opValid && opCode == OP_SAT_FRAC && srcOvf && !srcData[39]
    |=> wrData == 40'h007FFF0000 && dataOverflowFlag)
    else $error("frac positive clamp wrong");

  a_long_keep: assert property (@(posedge clk) disable iff (!rstSync) // RQ3
    opValid && opCode == OP_SAT_LONG && !srcOvf |=> wrData == $past(srcData)
    && !dataOverflowFlag)
    else $error("long saturate changed in-range value");

  a_long_clamp: assert property (@(posedge clk) disable iff (!rstSync) // RQ4
    opValid && opCode == OP_SAT_LONG && srcOvf |=>
    wrData == ($past(srcData[39]) ? 40'hFF80000000 : 40'h007FFFFFFF))
    else $error("long clamp wrong");

  a_sat_tag_clear: assert property (@(posedge clk) disable iff (!rstSync) // RQ6
    opValid && (opCode == OP_SAT_FRAC || opCode == OP_SAT_LONG) |=> !limitTag)
    else $error("saturate kept limit tag");

  sequence sbcIssue;
    opValid && opCode == OP_SUB_BORROW;
  endsequence

  a_sbc_result: assert property (@(posedge clk) disable iff (!rstSync) // RQ7
    sbcIssue |=> wrData == $past(pairSecond) - $past(pairFirst) - {39'h0, $past(carryIn)}
    && wrIdx[0] && carryWr)
    else $error("borrow subtract result wrong");

  a_sbc_carry: assert property (@(posedge clk) disable iff (!rstSync) // RQ9
    sbcIssue and (pairSecond < pairFirst) |=> carryOut)
    else $error("borrow not reported");

  a_sbr_sat_tag: assert property (@(posedge clk) disable iff (!rstSync) // RQ16
    opValid && opCode == OP_SUB_ROUND && saturationMode
    |=> !limitTag && (dataOverflowFlag || wrData[14:0] == 15'h0000))
    else $error("round in saturation mode kept tag");

  a_no_op_quiet: assert property (@(posedge clk) disable iff (!rstSync) // RQ20
    !opValid |=> !wrEn && !carryWr && !dataOverflowFlag)
    else $error("write without request");

  // ----------------------------------------------------------------
  // Result and flag checks
  // ----------------------------------------------------------------
  sequence satIssue;
    opValid && (opCode == OP_SAT_FRAC || opCode == OP_SAT_LONG);
  endsequence

  sequence sbrIssue;
    opValid && opCode == OP_SUB_ROUND;
  endsequence

  a_frac_neg_clamp: assert property (@(posedge clk) disable iff (!rstSync) // RQ2
    opValid && opCode == OP_SAT_FRAC && srcOvf && srcData[39]
    |=> wrData == NEG_CLAMP && dataOverflowFlag)
    else $error("frac negative clamp wrong");

  a_frac_copy: assert property (@(posedge clk) disable iff (!rstSync) // RQ1
    opValid && opCode == OP_SAT_FRAC && !srcOvf
    |=> wrData == ($past(srcData) & LOW_MASK) && !dataOverflowFlag)
    else $error("frac saturate altered in-range value");

  a_sat_no_carry: assert property (@(posedge clk) disable iff (!rstSync) // RQ20
    satIssue |=> wrEn && !carryWr)
    else $error("saturate touched the carry");

  a_sbc_index: assert property (@(posedge clk) disable iff (!rstSync) // RQ8
    sbcIssue |=> wrIdx == {$past(pairSel), 1'b1}
    && pairFirstIdx == {$past(pairSel), 1'b0} && pairSecondIdx == wrIdx)
    else $error("borrow subtract pair index wrong");

  a_sbc_no_borrow: assert property (@(posedge clk) disable iff (!rstSync) // RQ9
    sbcIssue ##0 (pairSecond > pairFirst) |=> !carryOut)
    else $error("borrow reported without one");

  a_sbc_overflow: assert property (@(posedge clk) disable iff (!rstSync) // RQ11
    sbcIssue |=> dataOverflowFlag == ($past(pairSecond[39]) != $past(pairFirst[39])
    && wrData[39] != $past(pairSecond[39])))
    else $error("borrow subtract overflow flag wrong");

  a_scale_up_tag: assert property (@(posedge clk) disable iff (!rstSync) // RQ17
    sbcIssue ##0 (scaleMode == SCALE_UP) |=> dataOverflowFlag
    || limitTag == !((&wrData[39:30]) || !(|wrData[39:30])))
    else $error("scale-up limit tag wrong");

  a_rnd_low_zero: assert property (@(posedge clk) disable iff (!rstSync) // RQ13
    sbrIssue ##0 !saturationMode |=> wrData[14:0] == 15'h0000)
    else $error("round left low bits set");

  a_rnd_clamp_range: assert property (@(posedge clk) disable iff (!rstSync) // RQ18
    sbrIssue ##0 saturationMode |=> (&wrData[39:31]) || !(|wrData[39:31]))
    else $error("round result outside 32-bit range");

  a_op_writes: assert property (@(posedge clk) disable iff (!rstSync) // RQ20
    opValid && opCode != OP_NONE |=> wrEn)
    else $error("operation did not write back");
endmodule : data_arith_unit_sat_sub

// ==== test/dreg_file_model.sv ====
// Data register file model that feeds the pair operands
`timescale 1ns/1ps
module dreg_file_model (
  // Clock
  input  wire logic        clk,
  // Write-back and preload
  input  wire logic        wrEn,
  input  wire logic [2:0]  wrIdx,
  input  wire logic [39:0] wrData,
  input  wire logic        ldEn,
  input  wire logic [2:0]  ldIdx,
  input  wire logic [39:0] ldData,
  // Pair read
  input  wire logic [1:0]  pairSel,
  output logic      [39:0] pairFirst,
  output logic      [39:0] pairSecond
);
  logic [39:0] regs [8];
  // Preload wins over write-back
  always_ff @(posedge clk) begin
    if (ldEn) regs[ldIdx] <= ldData;
    else if (wrEn) regs[wrIdx] <= wrData;
  end
  // Even register first, odd register second
  assign pairFirst  = regs[{pairSel, 1'b0}];
  assign pairSecond = regs[{pairSel, 1'b1}];
endmodule : dreg_file_model

// ==== test/data_arith_unit_sat_sub_tb.sv ====
// Self-checking bench for the saturate and subtract slice
`timescale 1ns/1ps
module data_arith_unit_sat_sub_tb;
  import data_arith_unit_sat_sub_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, opValid = 1'b0, ldEn = 1'b0;
  op_t         opCode = OP_NONE;
  logic [1:0]  pairSel = 2'h0, scaleMode = 2'h0;
  logic [2:0]  dstSel = 3'h0, ldIdx = 3'h0, wrIdx, pIdxA, pIdxB;
  logic [39:0] srcData = 40'h0, dstData = 40'h0, ldData = 40'h0;
  logic [39:0] wrData, pairFirst, pairSecond, eData;
  logic        saturationMode = 1'b0, roundSelect = 1'b0, carryIn = 1'b0;
  logic        wrEn, limitTag, carryOut, carryWr, dataOverflowFlag;
  logic        eTag, eOvf, eCry;
  int          errors = 0, nCompared = 0;
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  data_arith_unit_sat_sub data_arith_unit_sat_sub_inst (.clk, .nrst, .opValid, .opCode, .pairSel, .srcSel(3'h0),
    .dstSel, .srcData, .dstData, .pairFirst, .pairSecond, .saturationMode, .roundSelect,
    .scaleMode, .carryIn, .wrEn, .wrIdx, .wrData, .limitTag, .pairFirstIdx(pIdxA),
    .pairSecondIdx(pIdxB), .carryOut, .carryWr, .dataOverflowFlag);
  dreg_file_model dreg_file_model_inst (.clk, .wrEn, .wrIdx, .wrData, .ldEn, .ldIdx,
    .ldData, .pairSel, .pairFirst, .pairSecond);
  // Compare one value and count it
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic complete_run();
    $display("compared %0d errors %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  // Reset held three cycles, outputs quiet, then settle
  task automatic do_reset();
    nrst = 1'b0;
    opValid = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(40'({wrEn, carryWr, dataOverflowFlag}), 40'h0);
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask : do_reset
  // Launch one op and judge the answer one cycle later
  task automatic issue(input op_t op, input logic [2:0] idx, input logic sb);
    opValid = 1'b1;
    opCode = op;
    @(posedge clk);
    #1;
    check(40'(wrEn), 40'h1);
    check(40'(wrIdx), 40'(idx));
    check(wrData, eData);
    check(40'(limitTag), 40'(eTag));
    check(40'(dataOverflowFlag), 40'(eOvf));
    check(40'(carryWr), 40'(sb));
    if (sb) check(40'(carryOut), 40'(eCry));
  endtask : issue
  // Idle cycle or ignored op: no write, no flag
  task automatic idle(input logic v);
    opValid = v;
    opCode = OP_NONE;
    @(posedge clk);
    #1;
    check(40'({wrEn, carryWr, dataOverflowFlag}), 40'h0);
  endtask : idle
  // Saturate op with its expected clamp
  task automatic sat_op(input op_t op, input logic [39:0] v);
    logic ov;
    ov = !(&v[39:31] || ~|v[39:31]);
    eData = op == OP_SAT_FRAC ? v & LOW_MASK : v;
    if (ov) eData = v[39] ? NEG_CLAMP : (op == OP_SAT_FRAC ? FRAC_POS : LONG_POS);
    eTag = 1'b0;
    eOvf = ov;
    srcData = v;
    dstSel = 3'h3;
    issue(op, 3'h3, 1'b0);
  endtask : sat_op
  // Expected subtract, optionally rounded and clamped
  task automatic exp_sub(input logic [39:0] a, input logic [39:0] b, input logic rnd);
    logic [40:0] d;
    logic [40:0] z;
    logic [40:0] h;
    int          p;
    d = {b[39], b} - {a[39], a} - 41'(carryIn && !rnd);
    z = {1'b0, b} - {1'b0, a} - 41'(carryIn);
    eCry = z[40];
    // Rounding point per scaling mode
    p = scaleMode == SCALE_DOWN ? 16 : (scaleMode == SCALE_UP ? 14 : 15);
    h = 41'h1 << p;
    if (rnd) begin
      d = d + h;
      if (!roundSelect && (d & ((h << 1) - 41'h1)) == 41'h0) d[p + 1] = 1'b0;
      d = d & ~((h << 1) - 41'h1);
    end
    eOvf = d[40] != d[39];
    case (scaleMode)
      SCALE_DOWN: eTag = !(&d[40:32] || ~|d[40:32]);
      SCALE_UP:   eTag = !(&d[40:30] || ~|d[40:30]);
      default:    eTag = !(&d[40:31] || ~|d[40:31]);
    endcase
    eData = d[39:0];
    if (rnd && saturationMode) begin
      if (!(&d[40:31] || ~|d[40:31])) begin
        eData = d[40] ? NEG_CLAMP : LONG_POS;
        eOvf = 1'b1;
      end
      eTag = 1'b0;
    end
  endtask : exp_sub
  // Borrow subtract on a freshly loaded pair
  task automatic sbc_op(input logic [1:0] s, input logic [39:0] a, input logic [39:0] b);
    load_reg({s, 1'b0}, a);
    load_reg({s, 1'b1}, b);
    ldEn = 1'b0;
    pairSel = s;
    exp_sub(a, b, 1'b0);
    issue(OP_SUB_BORROW, {s, 1'b1}, 1'b1);
    check(40'({pIdxA, pIdxB}), 40'({s, 1'b0, s, 1'b1}));
  endtask : sbc_op
  // Round subtract into register 0
  task automatic sbr_op(input logic [39:0] a, input logic [39:0] b, input logic rs);
    roundSelect = rs;
    srcData = a;
    dstData = b;
    dstSel = 3'h0;
    exp_sub(a, b, 1'b1);
    issue(OP_SUB_ROUND, 3'h0, 1'b0);
  endtask : sbr_op
  // Preload one register of the model
  task automatic load_reg(input logic [2:0] i, input logic [39:0] v);
    opValid = 1'b0;
    ldEn = 1'b1;
    ldIdx = i;
    ldData = v;
    @(posedge clk);
    #1;
  endtask : load_reg
  // Hang guard
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    do_reset();
    for (int m = 0; m < 2; m++) begin
      saturationMode = m[0];
      sat_op(OP_SAT_FRAC, 40'h00846D0000);
      sat_op(OP_SAT_FRAC, 40'hFF12345678);
      sat_op(OP_SAT_FRAC, 40'h0012345678);
      sat_op(OP_SAT_LONG, 40'h00828B5E9E);
      sat_op(OP_SAT_LONG, 40'h8000000000);
      sat_op(OP_SAT_LONG, 40'hFF80000001);
    end
    idle(1'b1);
    idle(1'b0);
    saturationMode = 1'b0;
    for (int i = 0; i < 4; i++) begin
      scaleMode = 2'(i % 3);
      carryIn = i[0];
      sbc_op(2'(i), 40'hFFD0000000 + 40'(i), 40'h0020000000);
    end
    carryIn = 1'b0;
    sbc_op(2'h3, 40'hFFFFFFFFFF, 40'h7FFFFFFFFF);
    carryIn = 1'b1;
    sbc_op(2'h1, 40'h0000000003, 40'h0000000005);
    scaleMode = 2'h0;
    sbr_op(40'h0015390030, 40'h002AE70080, 1'b0);
    sbr_op(40'h0000000000, 40'h0000008000, 1'b0);
    sbr_op(40'h0000000000, 40'h0000008000, 1'b1);
    sbr_op(40'h0000000000, 40'h0000018000, 1'b0);
    sbr_op(40'h8000000000, 40'h7F00000000, 1'b0);
    scaleMode = SCALE_DOWN;
    sbr_op(40'h0000000000, 40'h0100010000, 1'b0);
    scaleMode = SCALE_UP;
    sbr_op(40'h0000000000, 40'h004000C000, 1'b1);
    scaleMode = SCALE_NONE;
    saturationMode = 1'b1;
    sbr_op(40'hFF80000000, 40'h007FFF0000, 1'b0);
    sbr_op(40'h007FFF0000, 40'hFF80000000, 1'b1);
    idle(1'b0);
    do_reset();
    idle(1'b0);
    complete_run();
  end
endmodule : data_arith_unit_sat_sub_tb
